//--- logic/drive_sup_pkg.sv
// package: constants and carrier types of the drive enable supervisor
package drive_sup_pkg;
  localparam int unsigned CLK_HZ = 50_000_000;
  localparam int unsigned SAMPLE_US = 500;
  localparam int unsigned SAMPLE_CYC = CLK_HZ / 1_000_000 * SAMPLE_US;
  localparam int unsigned NULL_MS = 100;
  localparam int unsigned NULL_CYC = CLK_HZ / 1000 * NULL_MS;
  localparam int unsigned NULL_SAMPLES = NULL_MS * 1000 / SAMPLE_US;
  localparam int unsigned WDOG_MS = 500;
  localparam int unsigned WDOG_CYC = CLK_HZ / 1000 * WDOG_MS;
  localparam int unsigned BLINK_MS = 250;
  localparam int unsigned BLINK_CYC = CLK_HZ / 1000 * BLINK_MS;
  localparam int unsigned DEBOUNCE_CYC = 1000;
  // analog full scale is +/-16383 counts for +/-10 V
  localparam logic signed [15:0] AN_FULL = 16'sh3fff;
  // 1.2 V and 1.0 V in low-gain counts
  localparam logic [14:0] GAIN_UP_TH = 15'h07ae;
  localparam logic [14:0] GAIN_DN_TH = 15'h0666;
  localparam logic [2:0] HIGH_GAIN_SHIFT = 3'h3;
  localparam logic [1:0] CONTACT_FAULT = 2'h0;
  localparam logic [1:0] CONTACT_DRIVE_UP = 2'h1;
  localparam logic [1:0] CONTACT_SELF_CLEAR = 2'h2;
  localparam logic [7:0] ACCEL_STEP = 8'h10;
  localparam logic [3:0] DISP_FAULT_U = 4'ha;
  localparam logic [3:0] DISP_FAULT_H = 4'hb;
  localparam logic [3:0] DISP_FAULT_O = 4'hc;
  localparam logic [3:0] DISP_FAULT_OTHER = 4'hd;

  typedef struct packed {
    logic remote_enable;
    logic cw_limit_ok;
    logic ccw_limit_ok;
  } discrete_in_t;

  typedef struct packed {
    logic arm_cmd;
    logic software_inhibit_cmd;
    logic halt_cmd;
    logic auto_null_command;
  } serial_cmd_t;

  typedef struct packed {
    logic undervoltage;
    logic motor_overheat;
    logic other_fault;
  } fault_in_t;

  typedef struct packed {
    logic bus_power;
    logic regen_active;
    logic regen_overload;
  } led_t;

  typedef enum logic [1:0] {
    NULL_IDLE = 2'b00,
    NULL_RUN = 2'b01,
    NULL_DONE = 2'b11
  } null_state_t;
endpackage : drive_sup_pkg

//--- logic/input_filter.sv
// module: one discrete input synchroniser and debounce filter
`timescale 1ns/1ps
module input_filter
(
  input wire logic i_core_clk,
  input wire logic i_sys_rst,
  input wire logic i_raw,
  output logic o_level,
  output logic o_rise
);
  import drive_sup_pkg::*;
  typedef struct packed {
    logic sync1;
    logic sync2;
    logic [9:0] count;
    logic level;
    logic rise;
  } filt_t;
  filt_t st;
  filt_t next_st;

  // ===========================================================
  // filter: level accepted once stable for the debounce time
  always_comb
  begin
    next_st = st;
    next_st.sync1 = i_raw;
    next_st.sync2 = st.sync1;
    next_st.rise = 1'b0;
    if (st.sync2 == st.level)
      next_st.count = '0;
    else if (st.count == 10'(DEBOUNCE_CYC - 1))
    begin
      next_st.count = '0;
      next_st.level = st.sync2;
      next_st.rise = st.sync2;
    end
    else
      next_st.count = st.count + 10'h001;
  end

  always_ff @(posedge i_core_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
      st <= '0;
    else
      st <= next_st;
  end

  assign o_level = st.level;
  assign o_rise = st.rise;
endmodule : input_filter

//--- logic/analog_front.sv
// module: dual gain analog acquisition with offset, dead zone and scale
`timescale 1ns/1ps
module analog_front
(
  input wire logic i_core_clk,
  input wire logic i_sys_rst,
  input wire logic signed [15:0] i_adc_data,
  input wire logic signed [15:0] i_bias,
  input wire logic [15:0] i_dead_zone_mask,
  input wire logic signed [15:0] i_scale,
  output logic o_gain_high,
  output logic o_sample,
  output logic signed [15:0] o_raw_analog_reading,
  output logic signed [31:0] o_command
);
  import drive_sup_pkg::*;
  typedef struct packed {
    logic [14:0] tick;
    logic gain_high;
    logic sample;
    logic signed [15:0] reading;
    logic signed [31:0] command;
  } af_t;
  af_t st;
  af_t next_st;
  logic signed [15:0] norm;
  logic signed [15:0] biased;
  logic [14:0] mag;

  // ===========================================================
  // acquisition
  always_comb
  begin
    norm = st.gain_high ? (i_adc_data >>> HIGH_GAIN_SHIFT) : i_adc_data;
    if (norm > AN_FULL)
      norm = AN_FULL;
    else if (norm < -AN_FULL)
      norm = -AN_FULL;
    mag = norm[15] ? 15'(-norm) : norm[14:0];
    biased = norm + i_bias;
    next_st = st;
    next_st.sample = 1'b0;
    if (st.tick == 15'(SAMPLE_CYC - 1))
    begin
      next_st.tick = '0;
      next_st.sample = 1'b1;
      next_st.reading = biased;
      next_st.command = (biased & $signed(i_dead_zone_mask)) * i_scale;
      if (st.gain_high && mag > GAIN_UP_TH)
        next_st.gain_high = 1'b0;
      else if (!st.gain_high && mag < GAIN_DN_TH)
        next_st.gain_high = 1'b1;
    end
    else
      next_st.tick = st.tick + 15'h0001;
  end

  always_ff @(posedge i_core_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
      st <= '{tick: '0, gain_high: 1'b1, sample: 1'b0,
              reading: '0, command: '0};
    else
      st <= next_st;
  end

  assign o_gain_high = st.gain_high;
  assign o_sample = st.sample;
  assign o_raw_analog_reading = st.reading;
  assign o_command = st.command;
endmodule : analog_front

//--- logic/servo_drive_enable_supervisor.sv
// module: enable, display, relay, limit and analog supervisor of a servo drive
// ===========================================================
`timescale 1ns/1ps
module servo_drive_enable_supervisor
(
  input wire logic i_core_clk,
  input wire logic i_sys_rst,
  input drive_sup_pkg::discrete_in_t i_inputs,
  input drive_sup_pkg::serial_cmd_t i_cmd,
  input drive_sup_pkg::fault_in_t i_faults,
  input wire logic i_bus_power,
  input wire logic i_regen_active,
  input wire logic i_regen_overload,
  input wire logic i_cpu_healthy,
  input wire logic i_safety_disabled,
  input wire logic [3:0] i_operating_selection,
  input wire logic i_accel_profile_select,
  input wire logic [1:0] i_output_contact_select,
  input wire logic signed [15:0] i_adc_data,
  input wire logic signed [15:0] i_input_bias,
  input wire logic [15:0] i_dead_zone_mask,
  input wire logic signed [15:0] i_torque_scale,
  input wire logic signed [15:0] i_velocity,
  output logic o_power_stage_on,
  output logic o_armed,
  output logic o_software_enable,
  output logic o_decimal_point,
  output logic [3:0] o_display_code,
  output logic o_gain_high,
  output logic signed [15:0] o_raw_analog_reading,
  output logic signed [15:0] o_bias_out,
  output logic signed [15:0] o_fine_bias,
  output logic signed [31:0] o_command,
  output logic o_watchdog_relay,
  output logic o_contact_relay,
  output drive_sup_pkg::led_t o_leds,
  output logic o_overvoltage_fault,
  output logic o_null_busy
);
  import drive_sup_pkg::*;

  typedef struct packed {
    logic sw_enable;
    logic ov_fault;
    logic latched_fault;
    logic armed;
    logic active;
    logic dp;
    logic [3:0] disp;
    logic [23:0] blink_cnt;
    logic blink;
    logic [24:0] wdog_cnt;
    logic wdog;
    logic contact;
    led_t leds;
    logic signed [31:0] command;
    logic [7:0] ramp_scale;
    null_state_t null_st;
    logic [7:0] null_n;
    logic signed [23:0] null_acc;
    logic signed [15:0] bias;
    logic signed [15:0] fine;
  } sup_t;
  sup_t st;
  sup_t next_st;

  logic en_level;
  logic en_rise;
  logic cw_ok;
  logic ccw_ok;
  logic sample;
  logic gain_high;
  logic signed [15:0] reading;
  logic signed [31:0] raw_cmd;
  logic any_fault;
  logic arm_event;
  logic signed [23:0] avg;
  logic signed [31:0] limited;
  logic signed [47:0] ramped;

  // ===========================================================
  // discrete input filters
  input_filter u_en
  (
    .i_core_clk(i_core_clk),
    .i_sys_rst(i_sys_rst),
    .i_raw(i_inputs.remote_enable),
    .o_level(en_level),
    .o_rise(en_rise)
  );

  input_filter u_cw
  (
    .i_core_clk(i_core_clk),
    .i_sys_rst(i_sys_rst),
    .i_raw(i_inputs.cw_limit_ok),
    .o_level(cw_ok),
    .o_rise()
  );

  input_filter u_ccw
  (
    .i_core_clk(i_core_clk),
    .i_sys_rst(i_sys_rst),
    .i_raw(i_inputs.ccw_limit_ok),
    .o_level(ccw_ok),
    .o_rise()
  );

  // ===========================================================
  // analog acquisition
  analog_front u_af
  (
    .i_core_clk(i_core_clk),
    .i_sys_rst(i_sys_rst),
    .i_adc_data(i_adc_data),
    .i_bias(st.bias),
    .i_dead_zone_mask(i_dead_zone_mask),
    .i_scale(i_torque_scale),
    .o_gain_high(gain_high),
    .o_sample(sample),
    .o_raw_analog_reading(reading),
    .o_command(raw_cmd)
  );

  // ===========================================================
  // supervisor next state
  always_comb
  begin
    next_st = st;
    ramped = '0;
    arm_event = i_cmd.arm_cmd | en_rise;
    avg = st.null_acc / 24'sd200;
    // fault state: inputs plus latched over-voltage
    next_st.ov_fault = st.ov_fault | i_regen_overload;
    if (arm_event && !i_regen_overload)
      next_st.ov_fault = 1'b0;
    // latched faults need an arm; undervoltage, overheat self clear
    next_st.latched_fault = st.latched_fault | i_faults.other_fault;
    if (arm_event && !i_faults.other_fault)
      next_st.latched_fault = 1'b0;
    any_fault = st.ov_fault | st.latched_fault | i_faults.undervoltage
                | i_faults.motor_overheat | i_faults.other_fault
                | i_regen_overload;
    // software enable
    if (i_cmd.software_inhibit_cmd || i_cmd.halt_cmd)
      next_st.sw_enable = 1'b0;
    else if (arm_event)
      next_st.sw_enable = 1'b1;
    next_st.armed = next_st.sw_enable & !any_fault;
    next_st.active = next_st.armed & en_level;
    // display
    if (st.blink_cnt == 24'(BLINK_CYC - 1))
    begin
      next_st.blink_cnt = '0;
      next_st.blink = !st.blink;
    end
    else
      next_st.blink_cnt = st.blink_cnt + 24'h000001;
    next_st.dp = next_st.active & (!i_safety_disabled | st.blink);
    if (!any_fault)
      next_st.disp = i_operating_selection;
    else if (!st.blink)
      next_st.disp = 4'hf;
    else if (i_faults.undervoltage)
      next_st.disp = DISP_FAULT_U;
    else if (i_faults.motor_overheat)
      next_st.disp = DISP_FAULT_H;
    else if (st.ov_fault)
      next_st.disp = DISP_FAULT_O;
    else
      next_st.disp = DISP_FAULT_OTHER;
    // watchdog relay
    if (!i_cpu_healthy)
    begin
      next_st.wdog_cnt = '0;
      next_st.wdog = 1'b0;
    end
    else if (st.wdog_cnt == 25'(WDOG_CYC - 1))
      next_st.wdog = 1'b1;
    else
      next_st.wdog_cnt = st.wdog_cnt + 25'h0000001;
    // configurable contact
    unique case (i_output_contact_select)
      CONTACT_DRIVE_UP: next_st.contact = next_st.active;
      CONTACT_FAULT: next_st.contact = !any_fault;
      CONTACT_SELF_CLEAR:
        next_st.contact = !(i_faults.undervoltage
                            | i_faults.motor_overheat);
      default: next_st.contact = !any_fault;
    endcase
    next_st.leds = '{bus_power: i_bus_power, regen_active: i_regen_active,
                     regen_overload: i_regen_overload};
    // travel limits
    limited = raw_cmd;
    if ((!cw_ok && raw_cmd > 32'sd0) || (!ccw_ok && raw_cmd < 32'sd0))
      limited = 32'sd0;
    if (sample)
    begin
      if (i_accel_profile_select && limited == 32'sd0 && raw_cmd != 32'sd0)
      begin
        if (st.ramp_scale > ACCEL_STEP)
          next_st.ramp_scale = st.ramp_scale - ACCEL_STEP;
        else
          next_st.ramp_scale = '0;
      end
      else
        next_st.ramp_scale = 8'hff;
      if (i_accel_profile_select && limited == 32'sd0 && raw_cmd != 32'sd0)
      begin
        ramped = raw_cmd * $signed({1'b0, next_st.ramp_scale});
        next_st.command = 32'(ramped >>> 8);
      end
      else
        next_st.command = limited;
    end
    // auto null
    unique case (st.null_st)
      NULL_IDLE:
        if (i_cmd.auto_null_command && st.active)
        begin
          next_st.null_st = NULL_RUN;
          next_st.null_n = '0;
          next_st.null_acc = '0;
        end
      NULL_RUN:
        if (!st.active)
          next_st.null_st = NULL_IDLE;
        else if (sample)
        begin
          next_st.null_acc = st.null_acc + 24'(i_velocity);
          if (st.null_n == 8'(NULL_SAMPLES - 1))
            next_st.null_st = NULL_DONE;
          else
            next_st.null_n = st.null_n + 8'h01;
        end
      NULL_DONE:
      begin
        next_st.bias = st.bias - 16'(avg >>> 3);
        next_st.fine = st.fine - 16'(avg - ((avg >>> 3) <<< 3));
        next_st.null_st = NULL_IDLE;
      end
      default: next_st.null_st = NULL_IDLE;
    endcase
  end

  // ===========================================================
  // state register
  always_ff @(posedge i_core_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      st <= '0;
      st.sw_enable <= 1'b1;
      st.ramp_scale <= 8'hff;
    end
    else
      st <= next_st;
  end

  // ===========================================================
  // outputs
  always_ff @(posedge i_core_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      o_gain_high <= 1'b1;
      o_raw_analog_reading <= '0;
    end
    else
    begin
      o_gain_high <= gain_high;
      o_raw_analog_reading <= reading;
    end
  end

  assign o_power_stage_on = st.active;
  assign o_armed = st.armed;
  assign o_software_enable = st.sw_enable;
  assign o_decimal_point = st.dp;
  assign o_display_code = st.disp;
  assign o_bias_out = st.bias;
  assign o_fine_bias = st.fine;
  assign o_command = st.command;
  assign o_watchdog_relay = st.wdog;
  assign o_contact_relay = st.contact;
  assign o_leds = st.leds;
  assign o_overvoltage_fault = st.ov_fault;
  assign o_null_busy = (st.null_st != NULL_IDLE);
endmodule : servo_drive_enable_supervisor

//--- dv/drive_sup_asserts.sv
// checker: port level assertions of the drive enable supervisor
`timescale 1ns/1ps
module drive_sup_asserts
(
  input wire logic i_core_clk,
  input wire logic i_sys_rst,
  input drive_sup_pkg::serial_cmd_t i_cmd,
  input drive_sup_pkg::fault_in_t i_faults,
  input wire logic i_bus_power,
  input wire logic i_regen_active,
  input wire logic i_regen_overload,
  input wire logic i_cpu_healthy,
  input wire logic i_safety_disabled,
  input wire logic [1:0] i_output_contact_select,
  input wire logic o_power_stage_on,
  input wire logic o_armed,
  input wire logic o_software_enable,
  input wire logic o_decimal_point,
  input wire logic o_gain_high,
  input wire logic o_watchdog_relay,
  input wire logic o_contact_relay,
  input drive_sup_pkg::led_t o_leds,
  input wire logic o_overvoltage_fault
);
  import drive_sup_pkg::*;
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_sys_rst);
  // ==========================================================
  // assertions
  active_needs_arm_a: assert property (
    o_power_stage_on |-> o_armed && o_software_enable)
    else $error("power stage on while not armed");
  fault_drop_a: assert property (
    (|i_faults) |=> !o_armed && !o_power_stage_on)
    else $error("fault did not drop the enable flags");
  stop_cmd_a: assert property (
    i_cmd.software_inhibit_cmd || i_cmd.halt_cmd |=> !o_software_enable)
    else $error("software enable survived a stop command");
  arm_cmd_a: assert property (
    i_cmd.arm_cmd && !i_cmd.software_inhibit_cmd && !i_cmd.halt_cmd
    |=> o_software_enable)
    else $error("arm command did not set software enable");
  point_off_a: assert property (
    !o_power_stage_on |-> !o_decimal_point)
    else $error("decimal point lit while stage off");
  point_steady_a: assert property (
    (o_power_stage_on && !i_safety_disabled) [*2] |-> o_decimal_point)
    else $error("decimal point not steady while enabled");
  leds_follow_a: assert property (
    1'b1 |=> o_leds == {$past(i_bus_power), $past(i_regen_active),
    $past(i_regen_overload)})
    else $error("indicators do not follow their inputs");
  overvolt_log_a: assert property (
    $rose(i_regen_overload) |-> ##[1:2] o_overvoltage_fault)
    else $error("regen overload did not log over-voltage");
  wdog_open_a: assert property (
    !i_cpu_healthy |-> ##[0:1] !o_watchdog_relay)
    else $error("watchdog relay closed with cpu unhealthy");
  drive_up_relay_a: assert property (
    i_output_contact_select == CONTACT_DRIVE_UP
    && $stable(i_output_contact_select) && o_contact_relay
    |-> o_power_stage_on)
    else $error("drive up relay closed while disabled");
  cover property ($rose(o_power_stage_on));
  cover property ($fell(o_armed) && o_software_enable);
  cover property ($fell(o_gain_high));
  cover property ($rose(o_gain_high));
endmodule : drive_sup_asserts

bind servo_drive_enable_supervisor drive_sup_asserts drive_sup_asserts_i (
  .i_core_clk, .i_sys_rst, .i_cmd, .i_faults, .i_bus_power,
  .i_regen_active, .i_regen_overload, .i_cpu_healthy, .i_safety_disabled,
  .i_output_contact_select, .o_power_stage_on, .o_armed,
  .o_software_enable, .o_decimal_point, .o_gain_high, .o_watchdog_relay,
  .o_contact_relay, .o_leds, .o_overvoltage_fault);

//--- dv/drive_ctrl_model.sv
// model: machine controller driving the discrete inputs and analog command
`timescale 1ns/1ps
module drive_ctrl_model
(
  input wire logic i_core_clk,
  input wire logic i_enable_req,
  input wire logic [1:0] i_limit_open,
  input wire logic signed [15:0] i_volts_code,
  output drive_sup_pkg::discrete_in_t o_inputs,
  output logic signed [15:0] o_adc_data
);
  import drive_sup_pkg::*;
  logic prev_req = 1'b0;
  logic [2:0] bounce = 3'h0;
  initial o_inputs = 3'b011;
  initial o_adc_data = 16'sh0000;
  // ==========================================================
  // contact chatter on each close of the enable switch
  always @(posedge i_core_clk)
  begin
    #2;
    if (i_enable_req && !prev_req)
      bounce = 3'h6;
    else if (bounce != 3'h0)
      bounce = bounce - 3'h1;
    prev_req = i_enable_req;
    o_inputs.remote_enable = i_enable_req & ~bounce[0];
    o_inputs.cw_limit_ok = ~i_limit_open[1];
    o_inputs.ccw_limit_ok = ~i_limit_open[0];
    o_adc_data = i_volts_code;
  end
endmodule : drive_ctrl_model

//--- dv/test_servo_drive_enable_supervisor.sv
// testbench: scenario tasks for the drive enable supervisor
`timescale 1ns/1ps
module test_servo_drive_enable_supervisor;
  import drive_sup_pkg::*;
  logic i_core_clk = 1'b0, i_sys_rst = 1'b1, en_req = 1'b0;
  serial_cmd_t i_cmd = '0;
  fault_in_t i_faults = '0;
  discrete_in_t i_inputs;
  logic i_bus_power = 1'b0, i_regen_active = 1'b0, i_regen_overload = 1'b0;
  logic i_cpu_healthy = 1'b1;
  logic [1:0] lim_open = 2'h0;
  logic [1:0] i_output_contact_select = CONTACT_DRIVE_UP;
  logic [15:0] i_dead_zone_mask = 16'hfff0;
  logic signed [15:0] i_adc_data, volts = 16'sh0000;
  logic signed [15:0] i_torque_scale = 16'sh0003;
  logic o_power_stage_on, o_armed, o_software_enable, o_decimal_point;
  logic o_gain_high, o_watchdog_relay, o_contact_relay, o_overvoltage_fault;
  logic [3:0] o_display_code;
  logic signed [15:0] o_raw_analog_reading;
  logic signed [31:0] o_command;
  led_t o_leds;
  int n_mismatch = 0, comparisons = 0, waited = 0;
  always #10 i_core_clk = ~i_core_clk;
  drive_ctrl_model drive_ctrl_model_i (.i_core_clk, .i_enable_req(en_req),
    .i_limit_open(lim_open),
    .i_volts_code(volts), .o_inputs(i_inputs), .o_adc_data(i_adc_data));
  servo_drive_enable_supervisor servo_drive_enable_supervisor_i (
    .i_core_clk, .i_sys_rst, .i_inputs, .i_cmd, .i_faults, .i_bus_power,
    .i_regen_active, .i_regen_overload, .i_cpu_healthy,
    .i_safety_disabled(1'b0), .i_operating_selection(4'h5),
    .i_accel_profile_select(1'b0), .i_output_contact_select, .i_adc_data,
    .i_input_bias(16'sh0000), .i_dead_zone_mask, .i_torque_scale,
    .i_velocity(16'sh0000), .o_power_stage_on, .o_armed,
    .o_software_enable, .o_decimal_point, .o_display_code, .o_gain_high,
    .o_raw_analog_reading, .o_bias_out(), .o_fine_bias(), .o_command,
    .o_watchdog_relay, .o_contact_relay, .o_leds, .o_overvoltage_fault,
    .o_null_busy());
  // ==========================================================
  // shared tasks
  task step(input int n);
    repeat (n) @(posedge i_core_clk);
    #1;
  endtask : step
  task wrap_up();
    if (n_mismatch == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : wrap_up
  task check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  function automatic logic probe(input int which);
    case (which)
      0: return o_power_stage_on;
      1: return o_gain_high;
      default: return o_raw_analog_reading != 16'sh0000;
    endcase
  endfunction : probe
  task wait_for(input int which, input logic lvl, input int lim);
    for (waited = 0; waited < lim && probe(which) !== lvl; waited++)
      step(1);
    if (waited >= lim)
    begin
      n_mismatch++;
      wrap_up();
    end
  endtask : wait_for
  task pulse(input serial_cmd_t c);
    i_cmd = c;
    step(1);
    i_cmd = '0;
    step(1);
  endtask : pulse
  // ==========================================================
  // scenarios
  task t_enable();
    check(o_software_enable, 1'b1);
    check(o_display_code, 4'h5);
    en_req = 1'b1;
    wait_for(0, 1'b1, 1200);
    check(waited > 1000, 1'b1);
    check(o_decimal_point, 1'b1);
    check(o_armed, 1'b1);
    check(o_contact_relay, 1'b1);
  endtask : t_enable
  task t_commands();
    pulse(4'b0100);
    check(o_software_enable, 1'b0);
    check(o_power_stage_on, 1'b0);
    check(o_contact_relay, 1'b0);
    i_output_contact_select = CONTACT_FAULT;
    pulse(4'b0001);
    check(o_contact_relay, 1'b1);
    pulse(4'b1100);
    check(o_software_enable, 1'b0);
    pulse(4'b1000);
    check(o_power_stage_on, 1'b1);
    pulse(4'b0010);
    check(o_software_enable, 1'b0);
  endtask : t_commands
  task t_fault_and_edge();
    i_faults.other_fault = 1'b1;
    step(2);
    check(o_armed, 1'b0);
    check(o_contact_relay, 1'b0);
    check(o_display_code inside {DISP_FAULT_OTHER, 4'hf}, 1'b1);
    i_faults = '0;
    en_req = 1'b0;
    step(1100);
    en_req = 1'b1;
    wait_for(0, 1'b1, 1200);
    check(o_software_enable, 1'b1);
  endtask : t_fault_and_edge
  task t_self_clear();
    i_output_contact_select = CONTACT_SELF_CLEAR;
    i_faults.undervoltage = 1'b1;
    step(2);
    check(o_contact_relay, 1'b0);
    i_faults = '0;
    step(3);
    check(o_contact_relay, 1'b1);
  endtask : t_self_clear
  task t_indicators();
    {i_bus_power, i_regen_active, i_regen_overload} = 3'h7;
    i_cpu_healthy = 1'b0;
    step(1);
    check(o_leds, 3'h7);
    step(1);
    check(o_overvoltage_fault, 1'b1);
    check(o_watchdog_relay, 1'b0);
    {i_bus_power, i_regen_active, i_regen_overload} = 3'h4;
  endtask : t_indicators
  task t_analog();
    lim_open = 2'h1;
    volts = 16'sh0488;
    wait_for(2, 1'b1, 26000);
    step(2);
    check(o_raw_analog_reading, 16'sh0091);
    check(o_command, 32'sh000001b0);
    lim_open = 2'h2;
    volts = 16'sh7fff;
    wait_for(1, 1'b0, 26000);
    check(waited > 24990 && waited < 25003, 1'b1);
    check(o_command, 32'sh00000000);
    volts = 16'sh0010;
    wait_for(1, 1'b1, 26000);
  endtask : t_analog
  initial
  begin
    step(16);
    i_sys_rst = 1'b0;
    step(1);
    t_enable();
    t_commands();
    t_fault_and_edge();
    t_self_clear();
    t_indicators();
    t_analog();
    wrap_up();
  end
endmodule : test_servo_drive_enable_supervisor
